// file: hw/self_program_control.sv
// Overview of operation
// - irq requested while enabled and store disarmed
// - concurrent-section op sets busy, blocks section
// - busy clears on re-enable store or fill
// - bit five always reads zero
// - re-enable store only when no op runs
// - re-enable write during fill discards buffer
// - lock store programs lock bits from low data
// - early load returns lock or fuse byte
// - page write from buffer to pointer page
// - stalling-section op halts cpu throughout
// - page erase of pointer page
// - plain arm fills buffer word from pair
// - arm clears on store, on end of the op a store starts, or window end
// - invalid lower patterns have no effect; here a write with bit four set still discards a loaded buffer
// - six lock bits, upper two read one
// - lock bits only rise by chip erase
// - general mode two locks programming, fuses
// - general mode three locks verify, boot locks
// - app pair 10/00 blocks app writes
// - app pair 00/01 blocks boot reads, irqs
// - boot pair 10/00 blocks boot writes
// - boot pair 00/01 blocks app reads, irqs
// - sixty-four words per page, six bits
// - pointer bits select page and word
// - timed ops last the minimum time
//
// The AHB-Lite slave port is this design's own decision.
module self_program_control
   import self_program_pkg::*;
#(
   parameter int unsigned OP_CYCLES = OP_MIN_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic storeStrobe,
   input wire store_req_s storeReq,
   input wire logic loadStrobe,
   input wire logic [15:0] loadZ,
   input wire logic cpuInBoot,
   input wire logic vectorsInBoot,
   input wire logic globalIntEnable,
   input wire logic [1:0] bootSizeSel,
   input wire logic [7:0] fuseLowByte,
   input wire logic chipErase,
   output logic programReadyIrq,
   output logic concurrentSectionBusy,
   output logic cpuHalt,
   output logic bufWrite,
   output buf_write_s bufWriteWord,
   output logic bufDiscard,
   output logic pageOpStart,
   output page_op_s pageOp,
   output logic lockReadValid,
   output logic [7:0] lockReadData,
   output logic loadDenied,
   output logic irqSuppress,
   output logic extProgLocked,
   output logic extVerifyLocked,
   output logic fuseLocked,
   output logic bootLockFrozen
);

   logic program_ready_irq_enable_ff; // ready interrupt enable
   logic store_enable_ff; // store armed or op running
   logic [3:0] cmd_ff; // re-enable, lock set, page write, page erase
   logic [2:0] armAge_ff; // cycles since arming
   logic opBusy_ff; // page operation in flight
   logic bufLoaded_ff; // buffer holds filled words
   logic [7:0] lockByte_ff; // lock byte, 0 = programmed
   logic wrPend_ff; // write data phase pending
   logic [7:0] wrIdx_ff; // register index of pending write
   logic timerStart, timerBusy, timerDone; // op timer handshake
   logic addrAccept, csrWrite, wrValid; // bus decode
   logic [4:0] wrLow; // written command pattern
   logic storeExec, fillExec, reenExec, lockExec, lockLoad, opStart; // decoded strobes
   logic [6:0] zPage, bootStart; // store page, first boot page
   logic targetBoot, targetStall, writeLocked, readLocked, loadBoot; // section checks
   logic [7:0] csrRead, lockRead; // read views

   self_program_op_timer #(
      .CYCLES(OP_CYCLES)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .start(timerStart),
      .busy(timerBusy),
      .done(timerDone)
   );

   // bus decode and request classification
   always_comb begin
      addrAccept = hsel && htrans[1] && hready;
      csrWrite = wrPend_ff && (wrIdx_ff == CSR_IDX);
      wrLow = hwdata[4:0];
      wrValid = (wrLow == PAT_REENABLE) || (wrLow == PAT_LOCKSET)
         || (wrLow == PAT_PAGE_WRITE_CMD) || (wrLow == PAT_PAGE_ERASE_CMD) || (wrLow == PAT_FILL);
      storeExec = storeStrobe && store_enable_ff && !timerBusy && !timerDone && (armAge_ff < STORE_WINDOW);
      zPage = storeReq.zPtr[13:7];
      case (bootSizeSel)
         2'b11: bootStart = BOOT_PAGE_SZ11;
         2'b10: bootStart = BOOT_PAGE_SZ10;
         2'b01: bootStart = BOOT_PAGE_SZ01;
         default: bootStart = BOOT_PAGE_SZ00;
      endcase
      targetBoot = zPage >= bootStart;
      targetStall = zPage >= STALL_START_PAGE;
      // pair 10 or 00 means low bit programmed
      writeLocked = targetBoot ? !lockByte_ff[4] : !lockByte_ff[2];
      fillExec = storeExec && (cmd_ff == 4'h0);
      reenExec = storeExec && cmd_ff[3];
      lockExec = storeExec && cmd_ff[2];
      opStart = storeExec && (cmd_ff[1] || cmd_ff[0]) && !writeLocked;
      timerStart = opStart || lockExec;
      lockLoad = loadStrobe && store_enable_ff && cmd_ff[2] && !opBusy_ff
         && (armAge_ff < LOAD_WINDOW);
      lockRead = lockByte_ff | LOCK_UNUSED;
      loadBoot = loadZ[13:7] >= bootStart; // pair 00 or 01 means high bit programmed
      readLocked = cpuInBoot ? (!loadBoot && !lockByte_ff[3])
         : (loadBoot && !lockByte_ff[5]);
      csrRead = {program_ready_irq_enable_ff, concurrentSectionBusy, 1'b0, cmd_ff, store_enable_ff};
   end

   // ahb-lite slave: zero wait states, always okay
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPend_ff <= 1'b0;
         wrIdx_ff <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wrPend_ff <= addrAccept && hwrite;
         wrIdx_ff <= haddr[9:2];
         if (addrAccept && !hwrite) begin
            // unmapped indices read as zero
            if (haddr[9:2] == CSR_IDX) begin
               hrdata <= {24'h00_0000, csrRead};
            end else if (haddr[9:2] == LOCK_IDX) begin
               hrdata <= {24'h00_0000, lockRead};
            end else begin
               hrdata <= 32'h0000_0000;
            end
         end
      end
   end

   // interrupt enable bit, written on any control write
   always_ff @(posedge clk) begin
      if (rst) begin
         program_ready_irq_enable_ff <= CSR_RESET[IE_BIT];
      end else if (csrWrite) begin
         program_ready_irq_enable_ff <= hwdata[IE_BIT];
      end
   end

   // arming, command bits and window counter
   always_ff @(posedge clk) begin
      if (rst) begin
         store_enable_ff <= CSR_RESET[EN_BIT];
         cmd_ff <= CSR_RESET[4:1];
         armAge_ff <= 3'h0;
      end else if (timerBusy || timerDone) begin
         // armed bit holds until the timed operation ends
         if (timerDone) begin
            store_enable_ff <= 1'b0;
            cmd_ff <= 4'h0;
         end
      end else if (storeExec) begin
         // stays armed only for a started timed operation
         store_enable_ff <= timerStart;
         cmd_ff <= timerStart ? cmd_ff : 4'h0;
      end else if (csrWrite && wrValid) begin
         // busy and reserved bits never taken from the bus
         store_enable_ff <= 1'b1;
         cmd_ff <= wrLow[4:1];
         armAge_ff <= 3'h0;
      end else if (store_enable_ff) begin
         if (armAge_ff == STORE_WINDOW - 3'h1) begin
            store_enable_ff <= 1'b0;
            cmd_ff <= 4'h0;
         end else begin
            armAge_ff <= armAge_ff + 3'h1;
         end
      end
   end

   // timed operation tracking and cpu halt
   always_ff @(posedge clk) begin
      if (rst) begin
         opBusy_ff <= 1'b0;
         cpuHalt <= 1'b0;
      end else if (opStart) begin
         opBusy_ff <= 1'b1;
         cpuHalt <= targetStall;
      end else if (timerDone) begin
         opBusy_ff <= 1'b0;
         cpuHalt <= 1'b0;
      end
   end

   // concurrent section busy flag; starts and clears never coincide
   always_ff @(posedge clk) begin
      if (rst) begin
         concurrentSectionBusy <= CSR_RESET[BUSY_BIT];
      end else if (opStart && !targetStall) begin
         concurrentSectionBusy <= 1'b1;
      end else if (fillExec || reenExec) begin
         // re-enable only reaches here with no op running
         concurrentSectionBusy <= 1'b0;
      end
   end

   // temporary buffer fill, discard and page operation strobes
   always_ff @(posedge clk) begin
      if (rst) begin
         bufWrite <= 1'b0;
         bufWriteWord <= '0;
         bufDiscard <= 1'b0;
         bufLoaded_ff <= 1'b0;
         pageOpStart <= 1'b0;
         pageOp <= '0;
      end else begin
         bufWrite <= fillExec;
         bufDiscard <= 1'b0;
         pageOpStart <= opStart;
         if (fillExec) begin
            // pointer bit zero ignored, word from bits six to one
            bufWriteWord.wordSel <= storeReq.zPtr[6:1];
            bufWriteWord.data <= storeReq.dataPair;
            bufLoaded_ff <= 1'b1;
         end else if (csrWrite && hwdata[RE_BIT] && bufLoaded_ff) begin
            bufDiscard <= 1'b1;
            bufLoaded_ff <= 1'b0;
         end else if (opStart && cmd_ff[1]) begin
            bufLoaded_ff <= 1'b0;
         end
         if (opStart) begin
            // data pair ignored, only the page is passed on
            pageOp.erase <= cmd_ff[0];
            pageOp.write <= cmd_ff[1];
            pageOp.page <= zPage;
         end
      end
   end

   // lock byte: lock stores only move bits toward programmed, chip erase restores all
   always_ff @(posedge clk) begin
      if (rst) begin
         lockByte_ff <= LOCK_RESET;
      end else if (chipErase) begin
         lockByte_ff <= LOCK_RESET;
      end else if (lockExec) begin
         // from the low data byte; high byte and pointer ignored
         lockByte_ff <= lockByte_ff & (storeReq.dataPair[7:0] | LOCK_UNUSED);
      end
   end

   // load answers: lock/fuse readback or section denial
   always_ff @(posedge clk) begin
      if (rst) begin
         lockReadValid <= 1'b0;
         lockReadData <= 8'h00;
         loadDenied <= 1'b0;
      end else begin
         lockReadValid <= lockLoad;
         if (lockLoad) begin
            lockReadData <= loadZ[0] ? lockRead : fuseLowByte;
         end
         // boot-side load into app, app-side load into boot, or concurrent-section load while busy
         loadDenied <= loadStrobe && !lockLoad && (readLocked
            || (concurrentSectionBusy && loadZ[13:7] < STALL_START_PAGE));
      end
   end

   // interrupt request and suppression, lock mode outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         programReadyIrq <= 1'b0;
         irqSuppress <= 1'b0;
         extProgLocked <= 1'b0;
         extVerifyLocked <= 1'b0;
         fuseLocked <= 1'b0;
         bootLockFrozen <= 1'b0;
      end else begin
         programReadyIrq <= program_ready_irq_enable_ff && globalIntEnable && !store_enable_ff;
         irqSuppress <= (vectorsInBoot && !cpuInBoot && !lockByte_ff[3])
            || (!vectorsInBoot && cpuInBoot && !lockByte_ff[5]);
         extProgLocked <= !lockByte_ff[0];
         fuseLocked <= !lockByte_ff[0];
         extVerifyLocked <= !lockByte_ff[0] && !lockByte_ff[1];
         bootLockFrozen <= !lockByte_ff[0] && !lockByte_ff[1];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_irq_level;
      (program_ready_irq_enable_ff && globalIntEnable && !store_enable_ff) |=> programReadyIrq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("ready irq missing");
   property p_busy_set;
      (opStart && !targetStall) |=> concurrentSectionBusy [*2];
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy flag not set");
   property p_busy_clear;
      (fillExec || reenExec) |=> !concurrentSectionBusy;
   endproperty
   a_busy_clear: assert property (p_busy_clear) else $error("busy flag not cleared");
   property p_reserved_zero;
      (addrAccept && !hwrite && haddr[9:2] == CSR_IDX) |=> !hrdata[RES_BIT];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
   property p_window_expiry;
      (store_enable_ff && !opBusy_ff && !timerBusy && !storeStrobe && !csrWrite
         && armAge_ff == 3'h3) |=> (!store_enable_ff && cmd_ff == 4'h0);
   endproperty
   a_window_expiry: assert property (p_window_expiry) else $error("arm not expired");
   property p_op_holds_arm;
      opBusy_ff |-> (store_enable_ff && (cmd_ff[1] || cmd_ff[0]));
   endproperty
   a_op_holds_arm: assert property (p_op_holds_arm) else $error("arm dropped early");
   property p_halt_stall;
      (opStart && targetStall) |=> (cpuHalt && timerBusy) [*8];
   endproperty
   a_halt_stall: assert property (p_halt_stall) else $error("cpu not halted");
   property p_lock_monotone;
      !chipErase |=> ((lockByte_ff & ~$past(lockByte_ff)) == 8'h00);
   endproperty
   a_lock_monotone: assert property (p_lock_monotone) else $error("lock bit erased");
   property p_invalid_ignored;
      (csrWrite && !wrValid && !storeExec && !opBusy_ff && !store_enable_ff) |=> !store_enable_ff;
   endproperty
   a_invalid_ignored: assert property (p_invalid_ignored) else $error("bad pattern armed");
   property p_locked_write;
      (storeExec && (cmd_ff[1] || cmd_ff[0]) && writeLocked) |=> !pageOpStart && !store_enable_ff;
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("locked page started");
   property p_lock_read;
      lockLoad |=> (lockReadValid
         && lockReadData == ($past(loadZ[0]) ? $past(lockRead) : $past(fuseLowByte)));
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock read wrong");
   c_fill: cover property (fillExec ##1 bufWrite);
   c_page_write: cover property (opStart && cmd_ff[1] ##1 pageOpStart);
   c_lock_read: cover property (lockLoad ##1 lockReadValid);
   c_discard: cover property (bufDiscard);

endmodule

// file: pkg/self_program_pkg.sv
package self_program_pkg;

   // register indices (byte address is four times the index)
   localparam logic [7:0] CSR_IDX = 8'h37;   // control/status register
   localparam logic [7:0] LOCK_IDX = 8'h38;  // lock byte readback

   // control/status field positions
   localparam int IE_BIT = 7;
   localparam int BUSY_BIT = 6;
   localparam int RES_BIT = 5;
   localparam int RE_BIT = 4;
   localparam int LOCKSET_BIT = 3;
   localparam int PAGE_WRITE_CMD_BIT = 2;
   localparam int PAGE_ERASE_CMD_BIT = 1;
   localparam int EN_BIT = 0;

   // valid lower-five-bit command patterns
   localparam logic [4:0] PAT_REENABLE = 5'h11;
   localparam logic [4:0] PAT_LOCKSET = 5'h09;
   localparam logic [4:0] PAT_PAGE_WRITE_CMD = 5'h05;
   localparam logic [4:0] PAT_PAGE_ERASE_CMD = 5'h03;
   localparam logic [4:0] PAT_FILL = 5'h01;

   // reset values
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] LOCK_RESET = 8'hFF;
   localparam logic [7:0] LOCK_UNUSED = 8'hC0;

   // arming windows in cycles
   localparam logic [2:0] STORE_WINDOW = 3'h4;
   localparam logic [2:0] LOAD_WINDOW = 3'h3;

   // flash operation timing
   localparam real OP_TIME_MIN_MS = 3.7;
   localparam real OP_TIME_MAX_MS = 4.5;
   localparam real CLK_FREQ_MHZ = 125.0;
   localparam int unsigned OP_MIN_CYCLES = int'($ceil(OP_TIME_MIN_MS * CLK_FREQ_MHZ * 1000.0));
   localparam int unsigned OP_MAX_CYCLES = int'($floor(OP_TIME_MAX_MS * CLK_FREQ_MHZ * 1000.0));

   // section boundaries as page numbers
   localparam logic [6:0] STALL_START_PAGE = 7'h70;
   localparam logic [6:0] BOOT_PAGE_SZ11 = 7'h7E;
   localparam logic [6:0] BOOT_PAGE_SZ10 = 7'h7C;
   localparam logic [6:0] BOOT_PAGE_SZ01 = 7'h78;
   localparam logic [6:0] BOOT_PAGE_SZ00 = 7'h70;

   // store instruction request from the cpu
   typedef struct packed {
      logic [15:0] zPtr;
      logic [15:0] dataPair;
   } store_req_s;

   // temporary buffer word write
   typedef struct packed {
      logic [5:0] wordSel;
      logic [15:0] data;
   } buf_write_s;

   // page operation start
   typedef struct packed {
      logic erase;
      logic write;
      logic [6:0] page;
   } page_op_s;

endpackage

// file: hw/self_program_op_timer.sv
module self_program_op_timer
   import self_program_pkg::*;
#(
   parameter int unsigned CYCLES = OP_MIN_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   output logic busy,
   output logic done
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_ff; // cycles left minus one

   // counts one operation of fixed length, done pulses as busy falls
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            cnt_ff <= CW'(CYCLES - 1);
            busy <= 1'b1;
         end else if (busy) begin
            if (cnt_ff == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - CW'(1);
            end
         end
      end
   end

endmodule

// file: verif/cpu_model.sv
// store and load issue of the cpu core, strobed by the bench
module cpu_model
   import self_program_pkg::*;
(
   input wire logic goStore,
   input wire logic goLoad,
   input wire logic [15:0] zIn,
   input wire logic [15:0] dIn,
   input wire logic halt,
   output logic storeStrobe,
   output store_req_s storeReq,
   output logic loadStrobe,
   output logic [15:0] loadZ
);
   timeunit 1ns;
   timeprecision 1ps;
   // strobes last exactly the cycle the bench asks for; a halted core issues nothing
   assign storeStrobe = goStore && !halt;
   assign loadStrobe = goLoad && !halt;
   // operands valid only with their strobe, inverted otherwise so stale data never matches
   assign storeReq = goStore ? {zIn, dIn} : {~zIn, ~dIn};
   assign loadZ = goLoad ? zIn : ~zIn;
endmodule

// file: verif/test_self_program_control.sv
// self-checking bench for the self-programming control block
module test_self_program_control
   import self_program_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CSR_A = {22'h0, CSR_IDX, 2'h0}; // csr byte address
   localparam logic [31:0] LOCK_A = {22'h0, LOCK_IDX, 2'h0}; // lock readback
   logic clk, rst, hsel, hwrite, goStore, goLoad, cpuInBoot, globalIntEnable, chipErase;
   logic [31:0] haddr, hwdata, hrdata, rd, seed;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] zIn, dIn, loadZ;
   logic [7:0] fuseLowByte, lockExp, lockReadData;
   logic [6:0] pg;
   logic [4:0] pat;
   logic hreadyout, hresp, storeStrobe, loadStrobe, programReadyIrq, concurrentSectionBusy;
   logic cpuHalt, bufWrite, bufDiscard, pageOpStart, lockReadValid, loadDenied, irqSuppress;
   logic extProgLocked, extVerifyLocked, fuseLocked, bootLockFrozen, seen, vectorsInBoot;
   store_req_s storeReq;
   buf_write_s bufWriteWord;
   page_op_s pageOp;
   int bad_count, comparisons;
   logic [4:0] badPat [7] = '{5'h00, 5'h07, 5'h13, 5'h1F, 5'h10, 5'h02, 5'h08}; // invalid codes
   logic [7:0] lockData [5] = '{8'hF3, 8'hFE, 8'hFC, 8'hFF, 8'hCF}; // lock stores

   // design under test, flash ops shortened to 20 cycles
   self_program_control #(.OP_CYCLES(20)) dut_u (
      .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .storeStrobe, .storeReq, .loadStrobe, .loadZ,
      .cpuInBoot, .vectorsInBoot, .globalIntEnable, .bootSizeSel(2'h0),
      .fuseLowByte, .chipErase, .programReadyIrq, .concurrentSectionBusy, .cpuHalt,
      .bufWrite, .bufWriteWord, .bufDiscard, .pageOpStart, .pageOp, .lockReadValid,
      .lockReadData, .loadDenied, .irqSuppress, .extProgLocked, .extVerifyLocked,
      .fuseLocked, .bootLockFrozen
   );
   // far-side cpu
   cpu_model cpu_u (
      .goStore, .goLoad, .zIn, .dIn, .halt(cpuHalt), .storeStrobe, .storeReq, .loadStrobe,
      .loadZ
   );

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // xorshift step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // lock byte after a lock store: bits only fall
   function automatic logic [7:0] lock_after(input logic [7:0] old, input logic [7:0] d);
      return old & (d | LOCK_UNUSED);
   endfunction
   // page lies in the concurrently readable section
   function automatic logic conc(input logic [6:0] p);
      return p < STALL_START_PAGE;
   endfunction

   // verdict and end of run
   task automatic close_out();
      if (bad_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // one comparison
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         close_out();
      end
   endtask
   // single word transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask
   // poll until the store enable bit drops
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, CSR_A, 32'h0, rd);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      if (rd[0] !== 1'b0) begin
         bad_count++;
         close_out();
      end
   endtask
   // one store instruction, results looked at just after its edge
   task automatic store(input logic [15:0] z, input logic [15:0] d);
      goStore <= 1'b1;
      zIn <= z;
      dIn <= d;
      @(posedge clk);
      goStore <= 1'b0;
      #1;
   endtask
   // one load instruction
   task automatic load(input logic [15:0] z);
      goLoad <= 1'b1;
      zIn <= z;
      @(posedge clk);
      goLoad <= 1'b0;
      #1;
   endtask

   // hang guard
   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      close_out();
   end

   // main sequence
   initial begin
      seed = 32'h3B82;
      bad_count = 0;
      comparisons = 0;
      lockExp = LOCK_RESET;
      rst = 1'b1;
      {hsel, hwrite, goStore, goLoad, cpuInBoot, globalIntEnable, chipErase} = 7'h00;
      vectorsInBoot = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      zIn = 16'h0;
      dIn = 16'h0;
      fuseLowByte = 8'h5A;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, CSR_A, 32'h0, rd);
      chk("csr reset", {24'h0, CSR_RESET}, rd);
      bus(1'b0, LOCK_A, 32'h0, rd);
      chk("lock reset", 32'hFF, rd);
      bus(1'b0, 32'hF0, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      // fill stores at every window age, last two too late
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         bus(1'b1, CSR_A, {27'h0, PAT_FILL}, rd);
         repeat (k) @(posedge clk);
         store(seed[31:16], seed[15:0]);
         chk("fill strobe", k < 4, bufWrite);
         if (k < 4) chk("fill word", {seed[22:17], seed[15:0]}, bufWriteWord);
         repeat (4) @(posedge clk);
         bus(1'b0, CSR_A, 32'h0, rd);
         chk("arm clear", 32'h0, rd);
      end
      // ready interrupt follows the store enable bit
      globalIntEnable <= 1'b1;
      bus(1'b1, CSR_A, 32'h81, rd);
      @(posedge clk);
      #1 chk("irq armed", 32'h0, programReadyIrq);
      repeat (6) @(posedge clk);
      #1 chk("irq idle", 32'h1, programReadyIrq);
      @(posedge clk);
      globalIntEnable <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("irq gie off", 32'h0, programReadyIrq);
      // invalid codes with read-only bits set neither arm nor start an operation
      foreach (badPat[i]) begin
         bus(1'b1, CSR_A, {24'h0, 3'h3, badPat[i]}, rd);
         store(16'h0, 16'h1234);
         chk("bad op", 32'h0, {bufWrite, pageOpStart});
         bus(1'b0, CSR_A, 32'h0, rd);
         chk("bad csr", 32'h0, rd);
         chk("okay", 32'h0, hresp);
      end
      // page erase and write in both sections
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         pg = (i < 2) ? {1'b0, seed[5:0]} : {4'hE, seed[2:0]};
         bus(1'b1, CSR_A, {27'h0, i[0] ? PAT_PAGE_WRITE_CMD : PAT_PAGE_ERASE_CMD}, rd);
         store({2'h0, pg, 7'h0}, seed[31:16]);
         chk("op start", {1'b1, ~i[0], i[0], pg}, {pageOpStart, pageOp});
         @(posedge clk);
         #1 chk("busy halt", {conc(pg), ~conc(pg)}, {concurrentSectionBusy, cpuHalt});
         bus(1'b0, CSR_A, 32'h0, rd);
         chk("en held", {conc(pg), 1'b1}, {rd[6], rd[0]});
         bus(1'b1, CSR_A, {27'h0, PAT_REENABLE}, rd);
         store(16'h0, 16'h0);
         chk("early reenable", conc(pg), concurrentSectionBusy);
         wait_idle();
         chk("after op", {conc(pg), 1'b0}, {concurrentSectionBusy, cpuHalt});
         pat = (i == 0) ? PAT_FILL : PAT_REENABLE;
         bus(1'b1, CSR_A, {27'h0, pat}, rd);
         store(16'h0, 16'h0);
         chk("busy clear", 32'h0, concurrentSectionBusy);
      end
      // reenable bit during a buffer load throws the data away
      bus(1'b1, CSR_A, {27'h0, PAT_FILL}, rd);
      store(16'h0002, 16'hBEEF);
      bus(1'b1, CSR_A, 32'h10, rd);
      seen = 1'b0;
      repeat (4) begin
         #1 seen = seen | bufDiscard;
         @(posedge clk);
      end
      chk("discard", 32'h1, seen);
      // early loads read fuse or lock byte, too late reads nothing
      for (int j = 0; j < 3; j++) begin
         seed = xs(seed);
         fuseLowByte <= seed[7:0];
         bus(1'b1, CSR_A, {27'h0, PAT_LOCKSET}, rd);
         repeat ((j == 2) ? 3 : j) @(posedge clk);
         load({15'h0, j[0]});
         chk("load valid", j < 2, lockReadValid);
         if (j < 2) chk("load data", j[0] ? lockExp : fuseLowByte, lockReadData);
         repeat (5) @(posedge clk);
      end
      // lock stores only program bits, modes follow
      foreach (lockData[i]) begin
         bus(1'b1, CSR_A, {27'h0, PAT_LOCKSET}, rd);
         store(16'h0, {8'hA5, lockData[i]});
         lockExp = lock_after(lockExp, lockData[i]);
         wait_idle();
         bus(1'b0, LOCK_A, 32'h0, rd);
         chk("lock byte", lockExp, rd);
         chk("prog lock", {2{~lockExp[0]}}, {extProgLocked, fuseLocked});
         chk("verify lock", {2{lockExp[1:0] == 2'h0}}, {extVerifyLocked, bootLockFrozen});
      end
      // both sections write-locked now
      for (int j = 0; j < 2; j++) begin
         pg = j[0] ? 7'h78 : 7'h10;
         bus(1'b1, CSR_A, {27'h0, PAT_PAGE_ERASE_CMD}, rd);
         store({2'h0, pg, 7'h0}, 16'h0);
         chk("locked op", 32'h0, pageOpStart);
         bus(1'b0, CSR_A, 32'h0, rd);
         chk("locked arm", 32'h0, rd);
      end
      // cross-section reads refused, interrupts suppressed
      for (int j = 0; j < 4; j++) begin
         cpuInBoot <= j[0];
         vectorsInBoot <= j[1];
         repeat (2) @(posedge clk);
         #1 chk("irq suppress", j[0] ^ j[1], irqSuppress);
         @(posedge clk);
         load(j[0] ? 16'h0100 : 16'h3C00);
         chk("cross read", 32'h1, loadDenied);
         @(posedge clk);
         load(j[0] ? 16'h3C00 : 16'h0100);
         chk("own read", 32'h0, loadDenied);
         @(posedge clk);
      end
      // full erase restores the lock byte
      chipErase <= 1'b1;
      @(posedge clk);
      chipErase <= 1'b0;
      bus(1'b0, LOCK_A, 32'h0, rd);
      chk("chip erase", 32'hFF, rd);
      close_out();
   end
endmodule
